// file: bdu_defs.svh
`ifndef BDU_DEFS_SVH
`define BDU_DEFS_SVH

// debug register selector codes on the access port
`define BDU_IDX_ADDR0      3'h0
`define BDU_IDX_ADDR3      3'h3
`define BDU_IDX_CAUSE      3'h6
`define BDU_IDX_CONTROL    3'h7

// control register layout
`define BDU_CTL_ARM_TASK0  0
`define BDU_CTL_ARM_ALL0   1
`define BDU_CTL_EXACT_TASK 8
`define BDU_CTL_EXACT_ALL  9
`define BDU_CTL_GUARD      13
`define BDU_CTL_FIELD0     16
`define BDU_CTL_FIELD_STEP 4
`define BDU_CTL_TASK_MASK  32'h0000_0155
`define BDU_CTL_WR_MASK    32'hFFFF_23FF
`define BDU_CTL_RESET      32'h0000_0000

// cause register layout
`define BDU_CAUSE_GUARD    13
`define BDU_CAUSE_STEP     14
`define BDU_CAUSE_TASK     15
`define BDU_CAUSE_WR_MASK  32'h0000_E00F
`define BDU_CAUSE_RESET    32'h0000_0000

// field encodings
`define BDU_TYPE_EXEC      2'h0
`define BDU_TYPE_WRITE     2'h1
`define BDU_TYPE_RDWR      2'h3
`define BDU_SIZE_1         2'h0
`define BDU_SIZE_2         2'h1
`define BDU_SIZE_4         2'h3

`endif

// file: bdu_pkg.sv
package bdu_pkg;
    typedef logic [31:0] bdu_word_t;
    typedef logic [1:0]  bdu_field_t;
    typedef logic [3:0]  bdu_bp_t;
endpackage

// file: bdu_breakpoint_unit.sv
`include "bdu_defs.svh"
// Overview of operation
// RULE_01: access type 00 execution, 01 writes, 11 reads or writes; 10 unused.
// RULE_02: execution breakpoints raised as faults, data breakpoints as traps after transfer.
// RULE_03: data access overlapping the breakpoint field matches; enabled match traps.
// RULE_04: software programs execution breakpoints with type and size both 00.
// RULE_05: execution breakpoint matches only the instruction start address, faults first.
// RULE_06: debug registers accessible only in real mode or privilege level 0.
// RULE_07: guard bit set makes any debug register access fault, any mode.
// RULE_08: guard bit cleared automatically on debug handler entry.
// RULE_09: either exact bit makes execution wait; data trap reported right after.
// RULE_10: software should enable exact matching with data breakpoints, else reports slip.
// RULE_11: task switch clears task exact bit, keeps global exact bit.
// RULE_12: execution breakpoints always reported exactly.
// RULE_13: breakpoint enabled by either arm bit; enabled match invokes debug handler.
// RULE_14: task switch clears four task arm bits, keeps global arm bits.
// RULE_15: hardware only sets cause flags; handler software clears them.
// RULE_16: on any enabled match, every matching breakpoint's hit flag is set.
// RULE_17: guard hit flag set when guarded register access caused the exception.
// RULE_18: step hit flag set when single-step trap flag caused the exception.
// RULE_19: task with trap marker: switch completes, trap before first instruction.
// RULE_20: resume flag suppresses execution breakpoint at the return address.
// RULE_21: size 00 one byte, 01 two bytes aligned, 11 four bytes aligned.
// RULE_22: after reset all breakpoints are disabled.
// RULE_23: four 32-bit linear address registers compared continuously.
// RULE_24: undefined type or size encodings never match.
// RULE_25: simultaneous causes give one request with all flags recorded.
module bdu_breakpoint_unit
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // debug register move port
    input  wire logic              dr_req,
    input  wire logic              dr_write,
    input  wire logic [2:0]        dr_index,
    input  bdu_pkg::bdu_word_t     dr_wdata,
    output bdu_pkg::bdu_word_t     dr_rdata,
    output logic                   dr_ack,
    output logic                   dr_priv_fault,
    // processor mode
    input  wire logic              real_mode,
    input  wire logic [1:0]        cpl,
    // instruction fetch side
    input  wire logic              ifetch_valid,
    input  bdu_pkg::bdu_word_t     ifetch_addr,
    input  wire logic              resume_suppress,
    // data access side
    input  wire logic              data_done,
    input  wire logic              data_write,
    input  bdu_pkg::bdu_word_t     data_addr,
    input  wire logic [1:0]        data_bytes_m1,
    // instruction and task events
    input  wire logic              instr_retire,
    input  wire logic              step_trap_flag,
    input  wire logic              task_switch,
    input  wire logic              task_trap_marker,
    input  wire logic              handler_entry,
    // debug exception request
    output logic                   dbg_req,
    output logic                   dbg_is_fault,
    output logic                   exact_wait,
    // register views
    output bdu_pkg::bdu_word_t     bkpt_control_reg,
    output bdu_pkg::bdu_word_t     bkpt_cause_reg
);
    import bdu_pkg::*;

    //------------------------------------------------------------
    // match helpers
    //------------------------------------------------------------
    function automatic bdu_word_t size_mask(input bdu_field_t sz);
        case (sz)
            `BDU_SIZE_1: size_mask = 32'hFFFF_FFFF;
            `BDU_SIZE_2: size_mask = 32'hFFFF_FFFE; // [RULE_21]
            `BDU_SIZE_4: size_mask = 32'hFFFF_FFFC; // [RULE_21]
            default:     size_mask = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic size_ok(input bdu_field_t sz);
        size_ok = (sz != 2'h2); // [RULE_24]
    endfunction

    // overlap of an access [a, a+n] with an aligned field; 33-bit ends avoid wrap
    function automatic logic overlaps(input bdu_word_t base, input bdu_field_t sz,
                                      input bdu_word_t a, input logic [1:0] n);
        logic [32:0] f_lo;
        logic [32:0] f_hi;
        logic [32:0] a_lo;
        logic [32:0] a_hi;
        f_lo = {1'b0, base & size_mask(sz)};
        f_hi = {1'b0, base | ~size_mask(sz)};
        a_lo = {1'b0, a};
        a_hi = a_lo + {31'h0, n};
        overlaps = (a_lo <= f_hi) && (a_hi >= f_lo); // [RULE_03]
    endfunction

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    bdu_word_t addr_q [4];
    bdu_word_t addr_d [4];
    bdu_word_t ctl_q;
    bdu_word_t ctl_d;
    bdu_word_t cause_q;
    bdu_word_t cause_d;
    bdu_word_t rdata_q;
    bdu_word_t rdata_d;
    logic      ack_q;
    logic      ack_d;
    logic      priv_q;
    logic      priv_d;
    logic      req_q;
    logic      req_d;
    logic      fault_q;
    logic      fault_d;
    bdu_bp_t   pend_hits_q;
    bdu_bp_t   pend_hits_d;
    logic      pend_q;
    logic      pend_d;

    //------------------------------------------------------------
    // breakpoint compare, continuous
    //------------------------------------------------------------
    bdu_bp_t    armed;
    bdu_bp_t    exec_hit;
    bdu_bp_t    data_hit;
    bdu_field_t acc_type [4];
    bdu_field_t acc_size [4];
    logic       exact_on;
    logic       guard_on;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            acc_type[i] = ctl_q[`BDU_CTL_FIELD0 + `BDU_CTL_FIELD_STEP * i +: 2];
            acc_size[i] = ctl_q[`BDU_CTL_FIELD0 + `BDU_CTL_FIELD_STEP * i + 2 +: 2];
            armed[i]    = ctl_q[`BDU_CTL_ARM_TASK0 + 2 * i]
                        | ctl_q[`BDU_CTL_ARM_ALL0 + 2 * i]; // [RULE_13]
            // start address compared within the size-masked field; prefixes are part of the fetch address
            exec_hit[i] = ifetch_valid && (acc_type[i] == `BDU_TYPE_EXEC)
                        && size_ok(acc_size[i])
                        && ((ifetch_addr & size_mask(acc_size[i]))
                            == (addr_q[i] & size_mask(acc_size[i]))); // [RULE_05] [RULE_23]
            data_hit[i] = data_done && size_ok(acc_size[i])
                        && (((acc_type[i] == `BDU_TYPE_WRITE) && data_write)
                            || (acc_type[i] == `BDU_TYPE_RDWR)) // [RULE_01] [RULE_24]
                        && overlaps(addr_q[i], acc_size[i], data_addr, data_bytes_m1);
        end
        exact_on = ctl_q[`BDU_CTL_EXACT_ALL] | ctl_q[`BDU_CTL_EXACT_TASK];
        guard_on = ctl_q[`BDU_CTL_GUARD];
    end

    //------------------------------------------------------------
    // event decode
    //------------------------------------------------------------
    logic    exec_fire;
    logic    guard_fire;
    logic    data_fire;
    logic    data_now;
    logic    step_fire;
    logic    task_fire;
    logic    dr_allowed;
    bdu_bp_t exec_seen;

    always_comb
    begin
        // resume flag masks execution hits at the return address
        exec_seen  = resume_suppress ? 4'h0 : exec_hit; // [RULE_20]
        exec_fire  = |(exec_seen & armed); // [RULE_12] [RULE_02]
        guard_fire = dr_req && guard_on; // [RULE_07]
        dr_allowed = real_mode || (cpl == 2'h0); // [RULE_06]
        data_fire  = |(data_hit & armed);
        // without exact matching the trap slips to the instruction end
        data_now   = (data_fire && exact_on) || (pend_q && instr_retire); // [RULE_09] [RULE_10]
        step_fire  = instr_retire && step_trap_flag; // [RULE_18]
        task_fire  = task_switch && task_trap_marker; // [RULE_19]
    end

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb
    begin
        addr_d      = addr_q;
        ctl_d       = ctl_q;
        cause_d     = cause_q;
        rdata_d     = rdata_q;
        ack_d       = 1'b0;
        priv_d      = 1'b0;
        pend_d      = pend_q;
        pend_hits_d = pend_hits_q;

        // register moves; guard check precedes privilege check
        if (dr_req && !guard_on)
        begin
            if (!dr_allowed)
                priv_d = 1'b1; // [RULE_06]
            else
            begin
                ack_d = 1'b1;
                if (dr_write)
                begin
                    if (dr_index <= `BDU_IDX_ADDR3)
                        addr_d[dr_index[1:0]] = dr_wdata; // [RULE_23]
                    else if (dr_index == `BDU_IDX_CONTROL)
                        ctl_d = dr_wdata & `BDU_CTL_WR_MASK;
                    else if (dr_index == `BDU_IDX_CAUSE)
                        cause_d = dr_wdata & `BDU_CAUSE_WR_MASK; // [RULE_15]
                end
                else
                begin
                    if (dr_index <= `BDU_IDX_ADDR3)
                        rdata_d = addr_q[dr_index[1:0]];
                    else if (dr_index == `BDU_IDX_CONTROL)
                        rdata_d = ctl_q;
                    else if (dr_index == `BDU_IDX_CAUSE)
                        rdata_d = cause_q;
                    else
                        rdata_d = 32'h0000_0000;
                end
            end
        end

        // task switch drops task-local arming, global bits kept
        if (task_switch)
            ctl_d = ctl_d & ~`BDU_CTL_TASK_MASK; // [RULE_11] [RULE_14]
        if (handler_entry)
            ctl_d[`BDU_CTL_GUARD] = 1'b0; // [RULE_08]

        // loose data hits wait for the instruction end
        if (data_fire && !exact_on)
        begin
            pend_d      = 1'b1;
            pend_hits_d = (pend_q && instr_retire) ? data_hit : (pend_hits_q | data_hit);
        end
        else if (pend_q && instr_retire)
        begin
            pend_d      = 1'b0;
            pend_hits_d = 4'h0;
        end

        // flags only set by hardware; set wins over a software write
        if (exec_fire)
            cause_d[3:0] = cause_d[3:0] | exec_seen; // [RULE_16]
        if (data_fire && exact_on)
            cause_d[3:0] = cause_d[3:0] | data_hit; // [RULE_16] [RULE_03]
        if (pend_q && instr_retire)
            cause_d[3:0] = cause_d[3:0] | pend_hits_q;
        if (guard_fire)
            cause_d[`BDU_CAUSE_GUARD] = 1'b1; // [RULE_17]
        if (step_fire)
            cause_d[`BDU_CAUSE_STEP] = 1'b1; // [RULE_18]
        if (task_fire)
            cause_d[`BDU_CAUSE_TASK] = 1'b1; // [RULE_19]

        // one request per cycle; a fault outranks any trap
        req_d   = exec_fire | guard_fire | data_now | step_fire | task_fire; // [RULE_25]
        fault_d = exec_fire | guard_fire; // [RULE_02]
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 4; i++)
                addr_q[i] <= 32'h0000_0000;
            ctl_q       <= `BDU_CTL_RESET; // [RULE_22]
            cause_q     <= `BDU_CAUSE_RESET;
            rdata_q     <= 32'h0000_0000;
            ack_q       <= 1'b0;
            priv_q      <= 1'b0;
            req_q       <= 1'b0;
            fault_q     <= 1'b0;
            pend_q      <= 1'b0;
            pend_hits_q <= 4'h0;
        end
        else
        begin
            addr_q      <= addr_d;
            ctl_q       <= ctl_d;
            cause_q     <= cause_d;
            rdata_q     <= rdata_d;
            ack_q       <= ack_d;
            priv_q      <= priv_d;
            req_q       <= req_d;
            fault_q     <= fault_d;
            pend_q      <= pend_d;
            pend_hits_q <= pend_hits_d;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign dr_rdata         = rdata_q;
    assign dr_ack           = ack_q;
    assign dr_priv_fault    = priv_q;
    assign dbg_req          = req_q;
    assign dbg_is_fault     = fault_q;
    assign exact_wait       = exact_on; // [RULE_09]
    assign bkpt_control_reg = ctl_q;
    assign bkpt_cause_reg   = cause_q;

endmodule

// file: bdu_chk.sv
`include "bdu_defs.svh"
module bdu_chk
(
    // clock and reset
    input wire logic          clk,
    input wire logic          sys_rst,
    // register move port
    input wire logic          dr_req,
    input wire logic          dr_write,
    input wire logic [2:0]    dr_index,
    input wire logic          real_mode,
    input wire logic [1:0]    cpl,
    input wire logic          dr_ack,
    // events
    input wire logic          ifetch_valid,
    input wire logic          data_done,
    input wire logic          instr_retire,
    input wire logic          step_trap_flag,
    input wire logic          task_switch,
    input wire logic          task_trap_marker,
    input wire logic          handler_entry,
    // request and register views
    input wire logic          dbg_req,
    input wire logic          dbg_is_fault,
    input bdu_pkg::bdu_word_t bkpt_control_reg,
    input bdu_pkg::bdu_word_t bkpt_cause_reg
);
    import bdu_pkg::*;
    logic g;
    logic ev_q;
    logic ev_d;
    assign g = bkpt_control_reg[`BDU_CTL_GUARD];
    // a pending data hit is flushed by a retire, so retire counts as a cause
    always_comb ev_d = ifetch_valid | data_done | instr_retire | task_switch | dr_req;
    always_ff @(posedge clk) ev_q <= sys_rst ? 1'b0 : ev_d;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_move_ack: assert property (dr_req && !g && (real_mode || cpl == 2'h0) |=> dr_ack)
        else $error("register move not acknowledged");
    a_guard_trap: assert property (dr_req && g |=> dbg_req && dbg_is_fault && !dr_ack
        && bkpt_cause_reg[`BDU_CAUSE_GUARD]) else $error("guarded move not faulted");
    a_guard_drop: assert property (handler_entry && !dr_req |=> !g)
        else $error("guard bit kept after handler entry");
    a_cause_sticky: assert property (!(dr_req && dr_write && dr_index == `BDU_IDX_CAUSE)
        |=> (bkpt_cause_reg & $past(bkpt_cause_reg)) == $past(bkpt_cause_reg))
        else $error("cause flag cleared by hardware");
    a_task_clear: assert property (task_switch && !dr_req && !handler_entry |=>
        (bkpt_control_reg & `BDU_CTL_TASK_MASK) == 32'h0 && (bkpt_control_reg
        | `BDU_CTL_TASK_MASK) == ($past(bkpt_control_reg) | `BDU_CTL_TASK_MASK))
        else $error("task switch mishandled enables");
    a_step_trap: assert property (instr_retire && step_trap_flag |=> dbg_req
        && bkpt_cause_reg[`BDU_CAUSE_STEP]) else $error("single step not reported");
    a_task_trap: assert property (task_switch && task_trap_marker |=> dbg_req
        && bkpt_cause_reg[`BDU_CAUSE_TASK]) else $error("task trap not reported");
    a_req_cause: assert property (dbg_req |-> ev_q)
        else $error("debug request without event");
    c_fault: cover property (dbg_req && dbg_is_fault && bkpt_cause_reg[0]);
    c_trap: cover property (dbg_req && !dbg_is_fault && bkpt_cause_reg[2]);
    c_guard: cover property (dr_req && g ##1 dbg_req);
endmodule
bind bdu_breakpoint_unit bdu_chk bdu_chk_inst (.clk, .sys_rst, .dr_req, .dr_write, .dr_index,
    .real_mode, .cpl, .dr_ack, .ifetch_valid, .data_done, .instr_retire, .step_trap_flag,
    .task_switch, .task_trap_marker, .handler_entry, .dbg_req, .dbg_is_fault,
    .bkpt_control_reg, .bkpt_cause_reg);

// file: bdu_cpu_model.sv
module bdu_cpu_model
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // request in, handler entry out
    input wire logic dbg_req,
    input wire logic slow,
    output logic     handler_entry
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial handler_entry = 1'b0;
    // pipeline vectors to the handler one or three cycles after a request
    always @(negedge clk)
    begin
        handler_entry = !sys_rst && (cnt == 1);
        if (sys_rst)
            cnt = 0;
        else if (cnt > 0)
            cnt--;
        else if (dbg_req)
            cnt = slow ? 3 : 1;
    end
endmodule

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bdu_pkg::*;
    // packed: type, size, address, bytes minus one, write, expected hit
    typedef logic [11:0] bdu_case_t;
    logic       clk, sys_rst, dr_req, dr_write, real_mode, ifetch_valid, resume_suppress;
    logic       data_done, data_write, instr_retire, step_trap_flag, task_switch, slow;
    logic       task_trap_marker, handler_entry, dr_ack, dr_priv_fault, dbg_req;
    logic       dbg_is_fault, exact_wait;
    logic [2:0] dr_index;
    logic [1:0] cpl, data_bytes_m1;
    bdu_word_t  dr_wdata, dr_rdata, ifetch_addr, data_addr, bkpt_control_reg, bkpt_cause_reg;
    int         n_errors = 0;
    int         n_checks = 0;
    bdu_case_t  cases [11] = '{12'hC40, 12'hC45, 12'hD41, 12'hD64, 12'hF71, 12'hF2F,
                               12'hF8C, 12'h450, 12'h453, 12'h852, 12'hE52};
    always #50 clk = ~clk;
    bdu_breakpoint_unit bdu_breakpoint_unit_inst (.clk, .sys_rst, .dr_req, .dr_write, .dr_index,
        .dr_wdata, .dr_rdata, .dr_ack, .dr_priv_fault, .real_mode, .cpl, .ifetch_valid,
        .ifetch_addr, .resume_suppress, .data_done, .data_write, .data_addr, .data_bytes_m1,
        .instr_retire, .step_trap_flag, .task_switch, .task_trap_marker, .handler_entry,
        .dbg_req, .dbg_is_fault, .exact_wait, .bkpt_control_reg, .bkpt_cause_reg);
    bdu_cpu_model bdu_cpu_model_inst (.clk, .sys_rst, .dbg_req, .slow, .handler_entry);
    // ----------------------------------------
    // access and check tasks
    // ----------------------------------------
    task automatic chk(input bdu_word_t got, input bdu_word_t exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic mv(input logic w, input logic [2:0] i, input bdu_word_t d);
        @(negedge clk);
        {dr_req, dr_write, dr_index, dr_wdata} = {1'b1, w, i, d};
        @(negedge clk);
        dr_req = 1'b0;
    endtask
    task automatic rd(input logic [2:0] i, input bdu_word_t e);
        mv(1'b0, i, 32'h0);
        chk(dr_ack, 1'h1);
        chk(dr_rdata, e);
    endtask
    task automatic pulse(input logic [3:0] ev);
        @(negedge clk);
        {ifetch_valid, data_done, instr_retire, task_switch} = ev;
        @(negedge clk);
        {ifetch_valid, data_done, instr_retire, task_switch} = 4'h0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        {sys_rst, real_mode} = 2'h3;
        {dr_req, dr_write, dr_index, dr_wdata, cpl, slow, resume_suppress} = '0;
        {ifetch_valid, ifetch_addr, data_done, data_write, data_addr, data_bytes_m1} = '0;
        {instr_retire, step_trap_flag, task_switch, task_trap_marker} = '0;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        chk(bkpt_control_reg, 32'h0);
        ifetch_addr = 32'h0000_1000;
        pulse(4'h8);
        chk(dbg_req, 1'h0);
        rd(3'h4, 32'h0);
        // guard bit left clear, else the read-back itself would be refused
        mv(1'b1, 3'h7, 32'hFFFF_DFFF);
        rd(3'h7, 32'hFFFF_03FF);
        chk(exact_wait, 1'h1);
        mv(1'b1, 3'h6, 32'hFFFF_FFFF);
        rd(3'h6, 32'h0000_E00F);
        mv(1'b1, 3'h6, 32'h0);
        {real_mode, cpl} = 3'h3;
        mv(1'b0, 3'h7, 32'h0);
        chk(dr_priv_fault, 1'h1);
        cpl = 2'h0;
        mv(1'b1, 3'h7, 32'h0);
        chk(dr_ack, 1'h1);
        $display("test registers done");
        mv(1'b1, 3'h0, 32'h0000_1000);
        mv(1'b1, 3'h1, 32'h0000_1000);
        mv(1'b1, 3'h7, 32'h0000_0001);
        ifetch_addr = 32'h0000_1001;
        pulse(4'h8);
        chk(dbg_req, 1'h0);
        {ifetch_addr, resume_suppress} = {32'h0000_1000, 1'b1};
        pulse(4'h8);
        chk(dbg_req, 1'h0);
        resume_suppress = 1'b0;
        pulse(4'h8);
        chk(dbg_req & dbg_is_fault, 1'h1);
        chk(bkpt_cause_reg, 32'h3);
        ifetch_addr = 32'h0000_1001;
        pulse(4'h8);
        chk(bkpt_cause_reg, 32'h3);
        mv(1'b1, 3'h6, 32'h0);
        $display("test execution done");
        mv(1'b1, 3'h2, 32'h0000_0005);
        foreach (cases[k])
        begin
            mv(1'b1, 3'h7, {4'h0, cases[k][9:8], cases[k][11:10], 24'h00_0220});
            {data_addr, data_bytes_m1, data_write} = {28'h0, cases[k][7:1]};
            pulse(4'h4);
            chk(dbg_req, cases[k][0]);
            chk(bkpt_cause_reg, {29'h0, cases[k][0], 2'h0});
            if (cases[k][0])
                chk(dbg_is_fault, 1'h0);
            mv(1'b1, 3'h6, 32'h0);
        end
        mv(1'b1, 3'h7, 32'h0300_0020);
        chk(exact_wait, 1'h0);
        {data_addr, data_write} = {32'h0000_0005, 1'b0};
        pulse(4'h4);
        chk(dbg_req, 1'h0);
        pulse(4'h2);
        chk(dbg_req, 1'h1);
        chk(bkpt_cause_reg, 32'h4);
        mv(1'b1, 3'h6, 32'h0);
        $display("test data done");
        slow = 1'b1;
        mv(1'b1, 3'h7, 32'h0000_2000);
        mv(1'b0, 3'h7, 32'h0);
        chk(dr_ack, 1'h0);
        chk(dbg_req & dbg_is_fault, 1'h1);
        chk(bkpt_cause_reg, 32'h0000_2000);
        repeat (4) @(negedge clk);
        rd(3'h7, 32'h0);
        mv(1'b1, 3'h6, 32'h0);
        $display("test guard done");
        mv(1'b1, 3'h7, 32'h0F0F_03FF);
        {step_trap_flag, task_trap_marker} = 2'h3;
        pulse(4'h3);
        chk(dbg_req, 1'h1);
        chk(dbg_is_fault, 1'h0);
        chk(bkpt_cause_reg, 32'h0000_C000);
        chk(bkpt_control_reg, 32'h0F0F_02AA);
        $display("test task switch done");
        finish_test();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        finish_test();
    end
endmodule
